// [verilog/debug_block_pkg.sv]
// Package: register map, field layout, reset values and carrier types of the debug block
package debug_block_pkg;

   // ***************************************************************
   // Register indices (byte address is four times the index)
   // ***************************************************************
   localparam logic [29:0] IDX_DEBUG_CONTROL     = 30'h0ffe010;
   localparam logic [29:0] IDX_DEBUG_STATE_FLAGS = 30'h0ffe012;
   localparam logic [29:0] IDX_TRACE_SETUP       = 30'h0ffe013;
   localparam logic [29:0] IDX_BREAKPOINT_0      = 30'h0ffe090;
   localparam logic [29:0] IDX_BREAKPOINT_1      = 30'h0ffe094;
   localparam logic [29:0] IDX_BREAKPOINT_2      = 30'h0ffe098;
   localparam logic [29:0] IDX_BREAKPOINT_3      = 30'h0ffe09c;
   localparam int unsigned NUM_BREAKPOINTS       = 4;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int unsigned CTL_HALT_BIT        = 7;
   localparam int unsigned CTL_HALT_ON_BP_BIT  = 6;
   localparam int unsigned CTL_BP_ALLOWED_BIT  = 5;
   localparam int unsigned BP_PC_EN_BIT        = 31;
   localparam int unsigned BP_HIT_BIT          = 30;
   localparam int unsigned BP_RD_EN_BIT        = 29;
   localparam int unsigned BP_WR_EN_BIT        = 28;
   localparam int unsigned BP_MASK_LSB         = 24;
   localparam int unsigned BP_MASK_WIDTH       = 4;
   localparam int unsigned BP_ADDR_WIDTH       = 24;
   localparam int unsigned TRACE_EN_BIT        = 7;
   localparam int unsigned TRACE_SIZE_WIDTH    = 3;

   // ***************************************************************
   // Reset values and constants
   // ***************************************************************
   localparam logic [7:0]  DEBUG_STATE_FLAGS_RESET = 8'h01;
   localparam logic [31:0] BREAKPOINT_RESET        = 32'h00000000;
   localparam logic [7:0]  TRACE_SETUP_RESET       = 8'h00;
   localparam logic [7:0]  DEBUG_CONTROL_RESET     = 8'h00;
   localparam logic [11:0] TRACE_MIN_EVENTS        = 12'h010;
   localparam logic [23:0] ADDR_ALL_ONES           = 24'hffffff;
   localparam logic [1:0]  RESP_OKAY               = 2'h0;
   localparam logic [1:0]  RESP_SLVERR             = 2'h2;

   // ***************************************************************
   // Carrier types
   // ***************************************************************
   typedef struct packed {
      logic [23:0] pc;
      logic        fetch_valid;
      logic [23:0] data_addr;
      logic        data_rd;
      logic        data_wr;
      logic        break_exec;
   } cpu_access_t;

   typedef struct packed {
      logic in_halt_mode;
      logic in_stop_mode;
      logic read_protect_on;
      logic tx_holding_full;
      logic rx_holding_empty;
   } cpu_status_t;

   typedef struct packed {
      logic        debug_halt_flag;
      logic        illegal_trap;
      logic        debug_breakpoint;
      logic        loop_on_breakpoint;
      logic        trace_record_on;
      logic [2:0]  trace_size_code;
      logic [11:0] trace_event_limit;
   } debug_out_t;

   typedef struct packed {
      logic                                  debug_halt_flag;
      logic                                  halt_on_breakpoint;
      logic                                  breakpoints_allowed;
      logic                                  software_break_hit;
      logic [7:0]                            debug_state_flags;
      logic [NUM_BREAKPOINTS-1:0][31:0]      breakpoint;
      logic                                  trace_record_on;
      logic [2:0]                            trace_size_code;
      logic                                  aw_full;
      logic [29:0]                           aw_idx;
      logic                                  w_full;
      logic [31:0]                           w_data;
      logic [3:0]                            w_strb;
      logic                                  bvalid;
      logic [1:0]                            bresp;
      logic                                  rvalid;
      logic [31:0]                           rdata;
      logic [1:0]                            rresp;
      logic                                  illegal_trap;
      logic                                  debug_breakpoint;
      logic                                  loop_on_breakpoint;
   } debug_state_t;

endpackage

// [verilog/debug_status_breakpoint_trace.sv]
// Module: debug status flags, four breakpoint comparators and trace setup behind AXI4-Lite
//
// Our own choice: register access over AXI4-Lite.
module debug_status_breakpoint_trace
   import debug_block_pkg::*;
(
   input  wire logic        aclk,       // System clock, 200 MHz
   input  wire logic        aresetn,    // Synchronous reset, active low
   input  wire logic [31:0] awaddr,     // Write address
   input  wire logic        awvalid,    // Write address valid
   output logic             awready,    // Write address ready
   input  wire logic [31:0] wdata,      // Write data
   input  wire logic [3:0]  wstrb,      // Write byte strobes
   input  wire logic        wvalid,     // Write data valid
   output logic             wready,     // Write data ready
   output logic [1:0]       bresp,      // Write response
   output logic             bvalid,     // Write response valid
   input  wire logic        bready,     // Write response ready
   input  wire logic [31:0] araddr,     // Read address
   input  wire logic        arvalid,    // Read address valid
   output logic             arready,    // Read address ready
   output logic [31:0]      rdata,      // Read data
   output logic [1:0]       rresp,      // Read response
   output logic             rvalid,     // Read data valid
   input  wire logic        rready,     // Read data ready
   input  wire cpu_access_t cpu_access, // Core access cycle: PC, data address, break
   input  wire cpu_status_t cpu_status, // Core and debug link status levels
   output debug_out_t       debug_out   // Halt, trap, break and trace controls
);

   // ***************************************************************
   // State
   // ***************************************************************
   debug_state_t s;
   debug_state_t next_s;

   logic [NUM_BREAKPOINTS-1:0] hw_hit;
   logic [NUM_BREAKPOINTS-1:0][29:0] bp_idx;

   assign bp_idx = {IDX_BREAKPOINT_3, IDX_BREAKPOINT_2, IDX_BREAKPOINT_1, IDX_BREAKPOINT_0};

   // ***************************************************************
   // Comparators
   // ***************************************************************
   function automatic logic masked_equal(input logic [23:0] a,
                                         input logic [23:0] b,
                                         input logic [3:0]  ignore);
      logic [23:0] keep;
      keep = ADDR_ALL_ONES << ignore;
      return ((a ^ b) & keep) == 24'h000000;
   endfunction

   always_comb begin
      for (int i = 0; i < NUM_BREAKPOINTS; i++) begin
         hw_hit[i] = (s.breakpoint[i][BP_PC_EN_BIT] && cpu_access.fetch_valid
                      && cpu_access.pc == s.breakpoint[i][BP_ADDR_WIDTH-1:0])
                   || (s.breakpoint[i][BP_RD_EN_BIT] && cpu_access.data_rd
                       && masked_equal(cpu_access.data_addr,
                                       s.breakpoint[i][BP_ADDR_WIDTH-1:0],
                                       s.breakpoint[i][BP_MASK_LSB +: BP_MASK_WIDTH]))
                   || (s.breakpoint[i][BP_WR_EN_BIT] && cpu_access.data_wr
                       && masked_equal(cpu_access.data_addr,
                                       s.breakpoint[i][BP_ADDR_WIDTH-1:0],
                                       s.breakpoint[i][BP_MASK_LSB +: BP_MASK_WIDTH]));
      end
   end

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      logic        do_write;
      logic        clear_break_hit;
      logic        any_event;
      logic [29:0] rd_idx;
      logic [31:0] wr_data;
      logic [3:0]  wr_strb;
      next_s = s;
      do_write = s.aw_full && s.w_full && !s.bvalid;
      clear_break_hit = 1'b0;
      any_event = (|hw_hit) || cpu_access.break_exec;
      rd_idx = araddr[31:2];
      wr_data = s.w_data;
      wr_strb = s.w_strb;
      next_s.illegal_trap = 1'b0;
      next_s.debug_breakpoint = 1'b0;
      next_s.loop_on_breakpoint = 1'b0;

      // Write channel capture, in either order
      if (awvalid && !s.aw_full) begin
         next_s.aw_full = 1'b1;
         next_s.aw_idx = awaddr[31:2];
      end
      if (wvalid && !s.w_full) begin
         next_s.w_full = 1'b1;
         next_s.w_data = wdata;
         next_s.w_strb = wstrb;
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end

      // Register write
      if (do_write) begin
         next_s.aw_full = 1'b0;
         next_s.w_full = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = RESP_OKAY;
         if (s.aw_idx == IDX_DEBUG_CONTROL) begin
            if (wr_strb[0]) begin
               next_s.debug_halt_flag = wr_data[CTL_HALT_BIT];
               next_s.halt_on_breakpoint = wr_data[CTL_HALT_ON_BP_BIT];
               next_s.breakpoints_allowed = wr_data[CTL_BP_ALLOWED_BIT];
               clear_break_hit = !wr_data[CTL_HALT_BIT];
            end
         end else if (s.aw_idx == IDX_TRACE_SETUP) begin
            if (wr_strb[0]) begin
               next_s.trace_record_on = wr_data[TRACE_EN_BIT];
               next_s.trace_size_code = wr_data[TRACE_SIZE_WIDTH-1:0];
            end
         end else if (s.aw_idx == IDX_DEBUG_STATE_FLAGS) begin
            next_s.bresp = RESP_OKAY;
         end else if (s.aw_idx == bp_idx[0] || s.aw_idx == bp_idx[1]
                      || s.aw_idx == bp_idx[2] || s.aw_idx == bp_idx[3]) begin
            for (int i = 0; i < NUM_BREAKPOINTS; i++) begin
               if (s.aw_idx == bp_idx[i]) begin
                  for (int b = 0; b < 4; b++) begin
                     if (wr_strb[b]) begin
                        next_s.breakpoint[i][8*b +: 8] = wr_data[8*b +: 8];
                     end
                  end
               end
            end
         end else begin
            next_s.bresp = RESP_SLVERR;
         end
      end

      // Read channel
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      if (arvalid && !s.rvalid) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = RESP_OKAY;
         next_s.rdata = 32'h00000000;
         if (rd_idx == IDX_DEBUG_CONTROL) begin
            next_s.rdata[CTL_HALT_BIT] = s.debug_halt_flag;
            next_s.rdata[CTL_HALT_ON_BP_BIT] = s.halt_on_breakpoint;
            next_s.rdata[CTL_BP_ALLOWED_BIT] = s.breakpoints_allowed;
         end else if (rd_idx == IDX_DEBUG_STATE_FLAGS) begin
            next_s.rdata[7:0] = s.debug_state_flags;
         end else if (rd_idx == IDX_TRACE_SETUP) begin
            next_s.rdata[TRACE_EN_BIT] = s.trace_record_on;
            next_s.rdata[TRACE_SIZE_WIDTH-1:0] = s.trace_size_code;
         end else if (rd_idx == bp_idx[0] || rd_idx == bp_idx[1]
                      || rd_idx == bp_idx[2] || rd_idx == bp_idx[3]) begin
            for (int i = 0; i < NUM_BREAKPOINTS; i++) begin
               if (rd_idx == bp_idx[i]) begin
                  next_s.rdata = s.breakpoint[i];
               end
            end
         end else begin
            next_s.rresp = RESP_SLVERR;
         end
      end

      // Hardware hits win over a software clear in the same cycle
      for (int i = 0; i < NUM_BREAKPOINTS; i++) begin
         if (hw_hit[i]) begin
            next_s.breakpoint[i][BP_HIT_BIT] = 1'b1;
         end
      end

      // Software break flag: the set wins over the clear
      if (clear_break_hit) begin
         next_s.software_break_hit = 1'b0;
      end
      if (cpu_access.break_exec) begin
         next_s.software_break_hit = 1'b1;
      end

      // Break event action
      if (any_event) begin
         if (s.breakpoints_allowed) begin
            next_s.debug_breakpoint = 1'b1;
            if (s.halt_on_breakpoint) begin
               next_s.debug_halt_flag = 1'b1;
            end else begin
               next_s.loop_on_breakpoint = 1'b1;
            end
         end else begin
            next_s.illegal_trap = 1'b1;
         end
      end

      // Status flag snapshot
      next_s.debug_state_flags = {s.debug_halt_flag,
                                  s.software_break_hit,
                                  cpu_status.in_halt_mode,
                                  cpu_status.in_stop_mode,
                                  cpu_status.read_protect_on,
                                  1'b0,
                                  cpu_status.tx_holding_full,
                                  cpu_status.rx_holding_empty};
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.debug_halt_flag <= DEBUG_CONTROL_RESET[CTL_HALT_BIT];
         s.halt_on_breakpoint <= DEBUG_CONTROL_RESET[CTL_HALT_ON_BP_BIT];
         s.breakpoints_allowed <= DEBUG_CONTROL_RESET[CTL_BP_ALLOWED_BIT];
         s.debug_state_flags <= DEBUG_STATE_FLAGS_RESET;
         s.breakpoint <= {NUM_BREAKPOINTS{BREAKPOINT_RESET}};
         s.trace_record_on <= TRACE_SETUP_RESET[TRACE_EN_BIT];
         s.trace_size_code <= TRACE_SETUP_RESET[TRACE_SIZE_WIDTH-1:0];
      end else begin
         s <= next_s;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign awready = !s.aw_full;
   assign wready  = !s.w_full;
   assign bvalid  = s.bvalid;
   assign bresp   = s.bresp;
   assign arready = !s.rvalid;
   assign rvalid  = s.rvalid;
   assign rdata   = s.rdata;
   assign rresp   = s.rresp;

   always_comb begin
      debug_out.debug_halt_flag = s.debug_halt_flag;
      debug_out.illegal_trap = s.illegal_trap;
      debug_out.debug_breakpoint = s.debug_breakpoint;
      debug_out.loop_on_breakpoint = s.loop_on_breakpoint;
      debug_out.trace_record_on = s.trace_record_on;
      debug_out.trace_size_code = s.trace_size_code;
      debug_out.trace_event_limit = TRACE_MIN_EVENTS << s.trace_size_code;
   end

endmodule

// [testbench/debug_properties.sv]
// Assertion checker bound to the debug block ports
module debug_properties
   import debug_block_pkg::*;
(
   input wire logic        aclk,       // System clock
   input wire logic        aresetn,    // Reset, active low
   input wire logic        awvalid,    // Write address valid
   input wire logic        awready,    // Write address ready
   input wire logic        wvalid,     // Write data valid
   input wire logic        wready,     // Write data ready
   input wire logic [1:0]  bresp,      // Write response
   input wire logic        bvalid,     // Write response valid
   input wire logic        bready,     // Write response ready
   input wire logic        arvalid,    // Read address valid
   input wire logic        arready,    // Read address ready
   input wire logic [31:0] rdata,      // Read data
   input wire logic        rvalid,     // Read data valid
   input wire logic        rready,     // Read data ready
   input wire cpu_access_t cpu_access, // Core access cycle
   input wire debug_out_t  debug_out   // Block controls
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ****************
   // Bus handshakes
   // ****************
   sequence w_take;
      awvalid && awready && wvalid && wready;
   endsequence
   // Write completes one edge after the take, bvalid shows one edge later
   sequence b_answer;
      ##2 bvalid;
   endsequence
   write_answer_a: assert property (w_take |-> b_answer)
      else $error("write response missing");
   read_answer_a: assert property (arvalid && arready |=> rvalid)
      else $error("read data missing");
   bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   read_release_a: assert property (rvalid && rready |=> !rvalid)
      else $error("read data not released");
   // ****************
   // Core events and trace
   // ****************
   sequence brk_cause;
      cpu_access.break_exec;
   endsequence
   sequence event_out;
      ##1 (debug_out.illegal_trap || debug_out.debug_breakpoint);
   endsequence
   break_event_a: assert property (brk_cause |-> event_out)
      else $error("break gave no event");
   trap_excl_a: assert property (!(debug_out.illegal_trap && debug_out.debug_breakpoint))
      else $error("trap and breakpoint together");
   loop_cause_a: assert property (debug_out.loop_on_breakpoint |-> debug_out.debug_breakpoint)
      else $error("loop without breakpoint");
   halt_set_a: assert property (debug_out.debug_breakpoint && !debug_out.loop_on_breakpoint
      |-> debug_out.debug_halt_flag)
      else $error("breakpoint did not halt");
   trace_size_a: assert property (debug_out.trace_event_limit
      == (12'h010 << debug_out.trace_size_code))
      else $error("trace limit wrong");
   reset_value_a: assert property ($rose(aresetn) |-> !debug_out.trace_record_on
      && debug_out.trace_size_code == 3'h0 && !debug_out.debug_halt_flag)
      else $error("reset value wrong");
   trap_cause_a: assert property (debug_out.illegal_trap |-> $past(cpu_access.break_exec
      || cpu_access.fetch_valid || cpu_access.data_rd || cpu_access.data_wr))
      else $error("trap without access");
endmodule

bind debug_status_breakpoint_trace debug_properties debug_properties_i (.aclk, .aresetn,
   .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready,
   .rdata, .rvalid, .rready, .cpu_access, .debug_out);

// [testbench/cpu_model.sv]
// Behavioural core model: fetch, data and break cycles plus status levels
module cpu_model
   import debug_block_pkg::*;
(
   input  wire logic       aclk,       // System clock
   input  wire debug_out_t debug_out,  // Halt and event outputs
   output cpu_access_t     cpu_access, // Access cycle to the block
   output cpu_status_t     cpu_status  // Status levels to the block
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************
   // Access cycles
   // ****************
   initial begin
      cpu_access = '0;
      cpu_status = 5'h01;
   end
   // Kind 0 fetch, 1 data read, 2 data write, 3 break instruction
   task automatic access(input logic [1:0] kind, input logic [23:0] a);
      @(posedge aclk);
      cpu_access.pc <= a;
      cpu_access.data_addr <= a;
      cpu_access.fetch_valid <= (kind == 2'h0) && !debug_out.debug_halt_flag;
      cpu_access.data_rd <= (kind == 2'h1);
      cpu_access.data_wr <= (kind == 2'h2);
      cpu_access.break_exec <= (kind == 2'h3) && !debug_out.debug_halt_flag;
      @(posedge aclk);
      cpu_access <= {~a, 1'b0, ~a, 3'h0};
   endtask
   task automatic set_status(input cpu_status_t s);
      @(posedge aclk);
      cpu_status <= s;
   endtask
endmodule

// [testbench/tb_debug_status_breakpoint_trace.sv]
// Self-checking bench for the debug status, breakpoint and trace block
module tb_debug_status_breakpoint_trace
   import debug_block_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, seed = 32'hcfdc;
   logic [3:0]  wstrb = '0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   cpu_access_t cpu_access;
   cpu_status_t cpu_status;
   debug_out_t  debug_out;
   int          miscompares = 0, n_compared = 0, n_trap = 0, n_bkpt = 0, n_loop = 0;
   localparam logic [31:0] A_CTL = {IDX_DEBUG_CONTROL, 2'b00};
   localparam logic [31:0] A_FLG = {IDX_DEBUG_STATE_FLAGS, 2'b00};
   localparam logic [31:0] A_TRC = {IDX_TRACE_SETUP, 2'b00};

   debug_status_breakpoint_trace debug_status_breakpoint_trace_i (.aclk, .aresetn, .awaddr,
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cpu_access, .cpu_status,
      .debug_out);
   cpu_model cpu_model_i (.aclk, .debug_out, .cpu_access, .cpu_status);

   always #2.5 aclk = ~aclk;
   always @(posedge aclk) begin
      if (debug_out.illegal_trap === 1'b1) n_trap++;
      if (debug_out.debug_breakpoint === 1'b1) n_bkpt++;
      if (debug_out.loop_on_breakpoint === 1'b1) n_loop++;
   end
   // ****************
   // Helpers
   // ****************
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] bp_addr(int i);
      return {IDX_BREAKPOINT_0 + 30'(4 * i), 2'b00};
   endfunction
   function automatic logic [31:0] flags_exp(logic h, logic b, cpu_status_t s);
      return {24'h0, h, b, s.in_halt_mode, s.in_stop_mode, s.read_protect_on, 1'b0,
              s.tx_holding_full, s.rx_holding_empty};
   endfunction
   task automatic tally_and_finish();
      $display("Counts: %0d compared, %0d mismatches", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic guard(int n);
      if (n >= 200) begin
         check("handshake wait", 32'h1, 32'h0);
         tally_and_finish();
      end
   endtask
   task automatic axi_wr(input logic [31:0] a, d, input logic [1:0] er);
      int   n;
      logic da, dw, ka, kw;
      n = 0;
      da = 1'b0;
      dw = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(negedge aclk);
         ka = awvalid && awready;
         kw = wvalid && wready;
         @(posedge aclk);
         if (ka === 1'b1) awvalid <= 1'b0;
         if (kw === 1'b1) wvalid <= 1'b0;
         da |= (ka === 1'b1);
         dw |= (kw === 1'b1);
         n++;
      end while (!(da && dw) && n < 200);
      do begin
         @(negedge aclk);
         n++;
      end while (bvalid !== 1'b1 && n < 200);
      guard(n);
      check("bresp", 32'(bresp), 32'(er));
      // Late ready makes the response stand for a cycle
      @(posedge aclk);
      bready <= 1'b1;
      @(posedge aclk);
      bready <= 1'b0;
   endtask
   task automatic rd_chk(input logic [31:0] a, exp, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(negedge aclk);
         n++;
      end while (arready !== 1'b1 && n < 200);
      @(posedge aclk);
      arvalid <= 1'b0;
      do begin
         @(negedge aclk);
         n++;
      end while (rvalid !== 1'b1 && n < 200);
      guard(n);
      check("rdata", rdata, exp);
      check("rresp", 32'(rresp), 32'(er));
      // Late ready makes the read data stand for a cycle
      @(posedge aclk);
      rready <= 1'b1;
      @(posedge aclk);
      rready <= 1'b0;
   endtask
   task automatic watch_try(int i, logic [31:0] bp, logic [1:0] kind, logic [23:0] at,
                            logic hit);
      axi_wr(bp_addr(i), bp, RESP_OKAY);
      cpu_model_i.access(kind, at);
      repeat (3) @(posedge aclk);
      rd_chk(bp_addr(i), bp | {1'b0, hit, 30'h0}, RESP_OKAY);
   endtask
   // ****************
   // Scenarios
   // ****************
   initial begin
      repeat (60000) @(posedge aclk);
      check("run time", 32'h1, 32'h0);
      tally_and_finish();
   end
   initial begin
      cpu_status_t s;
      logic [31:0] v, bp;
      logic [23:0] a, lo;
      logic [3:0]  m;
      int          t0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd_chk(A_FLG, 32'h01, RESP_OKAY);
      rd_chk(A_TRC, 32'h0, RESP_OKAY);
      for (int i = 0; i < 4; i++) rd_chk(bp_addr(i), 32'h0, RESP_OKAY);
      rd_chk(32'h100, 32'h0, RESP_SLVERR);
      axi_wr(32'h100, 32'hffffffff, RESP_SLVERR);
      $display("Test reset_values done");
      for (int k = 0; k < 8; k++) begin
         v = xs();
         s = v[4:0];
         cpu_model_i.set_status(s);
         repeat (3) @(posedge aclk);
         rd_chk(A_FLG, flags_exp(1'b0, 1'b0, s), RESP_OKAY);
      end
      axi_wr(A_FLG, 32'hff, RESP_OKAY);
      rd_chk(A_FLG, flags_exp(1'b0, 1'b0, s), RESP_OKAY);
      $display("Test status_flags done");
      for (int c = 0; c < 8; c++) begin
         v = xs();
         axi_wr(A_TRC, {24'h0, v[7], 4'hf, 3'(c)}, RESP_OKAY);
         rd_chk(A_TRC, {24'h0, v[7], 4'h0, 3'(c)}, RESP_OKAY);
         check("trace_event_limit", 32'(debug_out.trace_event_limit), 32'h10 << c);
         check("trace_record_on", 32'(debug_out.trace_record_on), 32'(v[7]));
      end
      $display("Test trace_setup done");
      v = xs();
      a = v[23:0];
      axi_wr(A_CTL, 32'h0, RESP_OKAY);
      axi_wr(bp_addr(0), {8'h80, a}, RESP_OKAY);
      t0 = n_trap;
      cpu_model_i.access(2'h0, a ^ 24'h800000);
      cpu_model_i.access(2'h0, a ^ 24'h000001);
      repeat (3) @(posedge aclk);
      rd_chk(bp_addr(0), {8'h80, a}, RESP_OKAY);
      cpu_model_i.access(2'h0, a);
      repeat (3) @(posedge aclk);
      check("trap count", 32'(n_trap - t0), 32'h1);
      rd_chk(bp_addr(0), {8'hc0, a}, RESP_OKAY);
      axi_wr(bp_addr(0), {8'h80, a}, RESP_OKAY);
      rd_chk(bp_addr(0), {8'h80, a}, RESP_OKAY);
      axi_wr(bp_addr(0), {8'h40, a}, RESP_OKAY);
      rd_chk(bp_addr(0), {8'h40, a}, RESP_OKAY);
      $display("Test pc_breakpoint done");
      axi_wr(A_CTL, 32'h60, RESP_OKAY);
      t0 = n_bkpt;
      cpu_model_i.access(2'h3, a);
      repeat (3) @(posedge aclk);
      check("breakpoint count", 32'(n_bkpt - t0), 32'h1);
      check("halt flag", 32'(debug_out.debug_halt_flag), 32'h1);
      rd_chk(A_FLG, flags_exp(1'b1, 1'b1, s), RESP_OKAY);
      axi_wr(A_CTL, 32'h20, RESP_OKAY);
      repeat (3) @(posedge aclk);
      rd_chk(A_FLG, flags_exp(1'b0, 1'b0, s), RESP_OKAY);
      check("halt flag", 32'(debug_out.debug_halt_flag), 32'h0);
      t0 = n_loop;
      cpu_model_i.access(2'h3, a);
      repeat (3) @(posedge aclk);
      check("loop count", 32'(n_loop - t0), 32'h1);
      check("halt flag", 32'(debug_out.debug_halt_flag), 32'h0);
      $display("Test software_break done");
      axi_wr(A_CTL, 32'h0, RESP_OKAY);
      for (int k = 0; k < 8; k++) begin
         v = xs();
         a = v[23:0];
         m = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : v[27:24];
         lo = xs() & ((24'h1 << m) - 24'h1);
         bp = {2'b00, v[28], ~v[28], m, a};
         watch_try(k % 4, bp, 2'h1, a ^ lo, v[28]);
         watch_try(k % 4, bp, 2'h2, a ^ lo, ~v[28]);
         watch_try(k % 4, bp, v[28] ? 2'h1 : 2'h2, a ^ (24'h1 << m), 1'b0);
      end
      $display("Test watchpoints done");
      tally_and_finish();
   end
endmodule
